// ===== core/sadc_core.sv
`timescale 1ns/1ns
`include "sadc_consts.svh"
module sadc_core
  import sadc_pkg::*;
#(
  parameter int CONV_CYC = `SADC_CONV_CYC
) (
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  // host control pins
  input  wire logic              CHIP_SELECT_N,
  input  wire logic              CONVERSION_TRIGGER_N,
  input  wire logic              READ_N,
  input  wire logic              HALF_SELECT,
  // digitised differential input from the analogue front end (two's complement)
  input  wire sadc_pkg::sadc_word_t ANALOG_DIFF,
  // status and track/hold switch control
  output logic                   BUSY,
  output logic                   INPUT_CONNECT,
  // data bus, three signals per pin
  output logic [15:0]            DATA_IN_UNUSED,
  output sadc_pkg::sadc_word_t   DATA_OUT,
  output logic [15:0]            DATA_OE
);
  import sadc_pkg::*;

  localparam logic [4:0] CONV_LAST = 5'(CONV_CYC - 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic cs_n;
  logic cv_n;
  logic rd_n;
  logic half;
  logic cv_prev;

  // chip select settles two edges after the pin
  sadc_sync2 #(
    .RST_VAL (1'b1)
  ) cs_sync_i (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .pin   (CHIP_SELECT_N),
    .level (cs_n)
  );

  // trigger uses the same delay, so both line up
  sadc_sync2 #(
    .RST_VAL (1'b1)
  ) cv_sync_i (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .pin   (CONVERSION_TRIGGER_N),
    .level (cv_n)
  );

  // read strobe, idle high
  sadc_sync2 #(
    .RST_VAL (1'b1)
  ) rd_sync_i (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .pin   (READ_N),
    .level (rd_n)
  );

  // byte select, idle low
  sadc_sync2 #(
    .RST_VAL (1'b0)
  ) hs_sync_i (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .pin   (HALF_SELECT),
    .level (half)
  );

  // previous settled trigger level for the edge detector
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cv_prev <= 1'b1; // idle level, no false edge after reset
    end else begin
      cv_prev <= cv_n;
    end
  end

  // trigger counts only with chip select low
  wire start = cv_prev & ~cv_n & ~cs_n;

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  sadc_state_t state;
  sadc_state_t next_state;
  logic [4:0]  count;
  logic [4:0]  next_count;
  sadc_word_t  sample;
  sadc_word_t  result;

  // conversion in flight and its last cycle
  wire busy_now = (state == SADC_CONVERT);
  wire done     = busy_now && (count == CONV_LAST);

  // trigger during a conversion is ignored; busy stays high
  always_comb begin
    next_state = state;
    case (state)
      SADC_IDLE:    if (start) next_state = SADC_CONVERT;
      SADC_CONVERT: if (done) next_state = SADC_IDLE;
      default:      next_state = SADC_IDLE;
    endcase
  end

  // cycle counter runs only while converting
  assign next_count = busy_now ? count + 5'h01 : 5'h00;

  // reset aborts regardless of chip select
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= SADC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // counter clears on reset so an aborted run leaves no residue
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      count <= 5'h00;
    end else begin
      count <= next_count;
    end
  end

  // hold the sample at the start edge only
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sample <= `SADC_RESULT_RST;
    end else begin
      if (state == SADC_IDLE && start) sample <= ANALOG_DIFF;
    end
  end

  // publish at the end only, so reads mid-conversion see the old word
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      result <= `SADC_RESULT_RST;
    end else begin
      if (done) result <= sample;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // bus lanes; the lower lane is filled in byte mode
  wire        read_en    = ~cs_n & ~rd_n;
  wire [7:0]  upper_lane = half ? result[7:0] : result[15:8];
  wire [7:0]  lower_lane = half ? `SADC_LOW_FILL : result[7:0];
  wire [15:0] bus_word   = {upper_lane, lower_lane};

  // data lanes come from flip-flops to keep the bus glitch free
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      DATA_OUT <= `SADC_RESULT_RST;
    end else begin
      DATA_OUT <= bus_word;
    end
  end

  // status straight from the state register; switch control from the state register gated by reset
  assign BUSY           = busy_now;
  assign INPUT_CONNECT  = (state == SADC_IDLE) & NRST;

  // enables are combinational from the settled strobes
  assign DATA_OE        = {16{read_en}};
  // bus is output only
  assign DATA_IN_UNUSED = 16'h0000;
endmodule

// ----------------------------------------
// two-stage pin synchroniser
// ----------------------------------------
module sadc_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw pin and its settled copy
  input  wire logic pin,
  output logic      level
);
  logic first;
  logic second;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first  <= RST_VAL;
      second <= RST_VAL;
    end else begin
      first  <= pin;
      second <= first;
    end
  end

  // only the second stage leaves the module
  assign level = second;
endmodule

// ===== inc/sadc_consts.svh
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SADC_CLK_NS        40
`define SADC_CONV_NS       650
// longest time rounds down
`define SADC_CONV_CYC      (`SADC_CONV_NS / `SADC_CLK_NS)
`define SADC_ACQ_NS        150
`define SADC_ACQ_CYC       ((`SADC_ACQ_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
// ----------------------------------------
// data layout
// ----------------------------------------
`define SADC_WIDTH         16
`define SADC_RESULT_RST    16'h0000
`define SADC_LOW_FILL      8'hFF
`endif

// ===== inc/sadc_pkg.sv
package sadc_pkg;
  typedef logic [15:0] sadc_word_t;
  typedef enum logic [0:0] {SADC_IDLE, SADC_CONVERT} sadc_state_t;
endpackage

// ===== sim/sadc_core_asserts.sv
`timescale 1ns/1ns
module sadc_core_asserts #(parameter int CONV_CYC = 16) (
  input wire logic        CORE_CLK, NRST, CHIP_SELECT_N, CONVERSION_TRIGGER_N,
  input wire logic        READ_N, HALF_SELECT, BUSY, INPUT_CONNECT,
  input wire logic [15:0] DATA_OE, DATA_OUT);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  sequence run; BUSY[*3] ##[1:CONV_CYC] !BUSY; endsequence
  a_busy_len: assert property ($rose(BUSY) |-> run) else $error("len");
  a_busy_go: assert property ($fell(CONVERSION_TRIGGER_N) && !CHIP_SELECT_N
    && !BUSY |-> ##[1:6] BUSY) else $error("go");
  a_in_apart: assert property (BUSY |-> !INPUT_CONNECT) else $error("iso");
  a_bus_off: assert property (CHIP_SELECT_N[*4] |-> !DATA_OE) else $error("off");
  a_bus_on: assert property ((!CHIP_SELECT_N && !READ_N)[*4] |-> &DATA_OE)
    else $error("on");
  a_old_kept: assert property (BUSY && $past(BUSY)
    && $past(HALF_SELECT, 2) == $past(HALF_SELECT, 3) |=> $stable(DATA_OUT)) else $error("old");
  a_low_fill: assert property ($past(NRST) && $past(NRST, 2) && $past(NRST, 3)
    && $past(HALF_SELECT, 3) |-> DATA_OUT[7:0] == 8'hFF) else $error("fill");
  a_reset_zero: assert property (disable iff (1'h0) !NRST |-> !DATA_OUT && !BUSY)
    else $error("rst");
endmodule
bind sadc_core sadc_core_asserts #(.CONV_CYC(CONV_CYC)) sadc_core_asserts_i (.*);

// ===== sim/sadc_core_bench.sv
`timescale 1ns/1ns
module sadc_core_bench;
  logic        CORE_CLK = 1'h0, NRST = 1'h1, HALF_SELECT = 1'h0;
  logic        CHIP_SELECT_N, CONVERSION_TRIGGER_N, READ_N, BUSY, INPUT_CONNECT;
  logic [15:0] ANALOG_DIFF = 16'h0000, DATA_OUT, DATA_OE;
  int          n_mismatch = 0, samples_checked = 0;
  bit          ok;
  // input word, half select, bus word
  logic [32:0] rows [3] = '{{16'h1234, 1'h1, 16'h34FF}, {16'h7FFF, 1'h0, 16'h7FFF},
    {16'h8000, 1'h0, 16'h8000}};
  always #20 CORE_CLK = ~CORE_CLK;
  sadc_core #(.CONV_CYC(4)) sadc_core_i (.*, .DATA_IN_UNUSED());
  sadc_host sadc_host_i (.*);
  task automatic check(logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) n_mismatch++;
    if (seen !== exp) $display("ERROR %0t got %h want %h", $time, seen, exp);
  endtask
  task automatic conclude;
    $display("%0d of %0d failed", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // table, then a data-lane check mid-conversion with the read strobe high, followed by a reset in flight
  initial begin
    NRST <= 1'h0;
    repeat (3) @(negedge CORE_CLK) check(DATA_OUT | DATA_OE, 16'h0000);
    @(posedge CORE_CLK) NRST <= 1'h1;
    foreach (rows[i]) begin
      {ANALOG_DIFF, HALF_SELECT} <= rows[i][32:16];
      sadc_host_i.convert(ok);
      if (!ok) n_mismatch++;
      if (!ok) conclude;
      @(negedge CORE_CLK) check(DATA_OUT & DATA_OE, rows[i][15:0]);
      @(posedge CORE_CLK);
    end
    ANALOG_DIFF <= 16'h0001;
    fork
      sadc_host_i.convert(ok);
      begin
        repeat (7) @(negedge CORE_CLK);
        check({BUSY, INPUT_CONNECT, DATA_OUT[13:0]}, 16'h8000);
        @(posedge CORE_CLK) NRST <= 1'h0;
        @(negedge CORE_CLK) check({BUSY, DATA_OUT[14:0]} | DATA_OE, 16'h0000);
        @(posedge CORE_CLK) NRST <= 1'h1;
      end
    join
    @(negedge CORE_CLK) check(DATA_OUT ^ DATA_OE, 16'hFFFF);
    conclude;
  end
endmodule

// ===== sim/sadc_host.sv
`timescale 1ns/1ns
module sadc_host (input wire logic CORE_CLK, BUSY,
  output logic CHIP_SELECT_N = 1'h1, CONVERSION_TRIGGER_N = 1'h1, READ_N = 1'h1);
  // select first so the trigger never races the select sync
  task automatic convert(output bit ok);
    int n;
    {CHIP_SELECT_N, READ_N} <= 2'h1;
    @(posedge CORE_CLK) CONVERSION_TRIGGER_N <= 1'h0;
    @(posedge CORE_CLK) CONVERSION_TRIGGER_N <= 1'h1;
    for (n = 0; n < 8 && !BUSY; n++) @(posedge CORE_CLK);
    for (n = 0; n < 40 && BUSY; n++) @(posedge CORE_CLK);
    ok = n > 0 && n < 40;
    repeat (4) @(posedge CORE_CLK);
    READ_N <= 1'h0;
    repeat (4) @(posedge CORE_CLK);
  endtask
endmodule
